// ==== src/one_pin_device.sv ====
// Device end: mode select and two-byte command decoder
// Contract
// - Line high forces fixed-frequency mode immediately
// - Stay fixed-frequency during whole command reception
// - Falling edge starts bit period decoding
// - Long low timeout enables power-save mode
// - Command inside timeout window is discarded
// - Host sends command before going power-save
// - First byte is fixed address, MSB first
// - Second byte: ack flag, select, value
// - Ack pull-down only when flag set
// - Host provides pull-up on shared line
// - Push-pull host never requests acknowledge
// - Bit value from high/low time ratio
// - Bytes MSB first, start and end-of-stream
// - Ack after delay, bounded pulse, valid command
`timescale 1ns/10ps
module one_pin_device
  import one_pin_pkg::*;
#(
  parameter int TIMEOUT   = one_pin_pkg::TIMEOUT_CYCLES,
  parameter int ACK_DELAY = one_pin_pkg::ACK_DELAY_CYCLES,
  parameter int ACK_PULSE = one_pin_pkg::ACK_PULSE_CYCLES,
  parameter int EOS       = one_pin_pkg::EOS_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  one_pin_if.device link,
  output logic      o_forced_pwm,
  output logic      o_cmd_valid,
  output logic [1:0] o_reg_select,
  output logic [4:0] o_value,
  output logic      o_ack_flag
);
  import one_pin_pkg::*;

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_ACK_WAIT, ST_ACK} state_e;

  // Decoder state
  state_e            state_q, state_d;
  logic              line_q, line_d;
  logic [CNT_W-1:0]  low_q, low_d;
  logic [CNT_W-1:0]  high_q, high_d;
  logic [4:0]        nbits_q, nbits_d;
  logic [15:0]       shift_q, shift_d;
  logic              fpwm_q, fpwm_d;
  logic              valid_q, valid_d;
  logic [1:0]        sel_q, sel_d;
  logic [4:0]        val_q, val_d;
  logic              flag_q, flag_d;
  logic              oe_q, oe_d;
  logic              fall;
  logic              bit_one, bit_zero;
  logic              bad_q, bad_d;

  // Line edge and bit ratio
  assign fall = line_q & ~link.line;
  // Ratio test with 2x margin
  assign bit_one  = (high_q >= (low_q << 1));
  assign bit_zero = (low_q >= (high_q << 1));

  // Next-state logic
  always_comb begin
    state_d = state_q;
    line_d  = link.line;
    low_d   = low_q;
    high_d  = high_q;
    nbits_d = nbits_q;
    shift_d = shift_q;
    fpwm_d  = fpwm_q;
    valid_d = 1'b0;
    sel_d   = sel_q;
    val_d   = val_q;
    flag_d  = flag_q;
    bad_d   = bad_q;
    oe_d    = 1'b1;
    if (link.line) begin
      fpwm_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (fall) begin
          state_d = ST_LOW;
          low_d   = '0;
          high_d  = '0;
          nbits_d = '0;
          bad_d   = 1'b0;
        end
      end

      ST_LOW: begin
        if (link.line) begin
          state_d = ST_HIGH;
          high_d  = CNT_W'(1);
        end else if (low_q >= CNT_W'(TIMEOUT - 1)) begin
          state_d = ST_IDLE; // Timeout abandons decoding
          fpwm_d  = 1'b0;
        end else begin
          low_d = low_q + CNT_W'(1); // Mode held during bit
        end
      end

      ST_HIGH: begin
        if (fall) begin
          // Bit closes at next falling edge, MSB first
          if (bit_one || bit_zero) begin
            shift_d = {shift_q[14:0], bit_one};
            nbits_d = nbits_q + 5'd1;
            if (nbits_q == 5'(CMD_BITS - 1)) begin
              state_d = ST_ACK_WAIT;
              low_d   = '0;
            end else begin
              state_d = ST_LOW;
              low_d   = '0;
            end
          end else begin
            state_d = ST_LOW; // Ambiguous bit: command invalid
            low_d   = '0;
            nbits_d = 5'd31;
            // Bad bit spoils the whole command
            bad_d   = 1'b1;
          end
        end else if (high_q >= CNT_W'(EOS)) begin
          state_d = ST_IDLE; // Long high is end-of-stream, back to idle
        end else begin
          high_d = high_q + CNT_W'(1);
        end
      end

      ST_ACK_WAIT: begin
        low_d = low_q + CNT_W'(1);
        if (low_q == '0) begin
          // Address check and field split
          if (shift_q[15:8] == DEV_ADDR && !bad_q) begin
            valid_d = 1'b1;
            flag_d  = shift_q[ACK_FLAG_POS];
            sel_d   = shift_q[SEL_HI_POS:SEL_LO_POS];
            val_d   = shift_q[VALUE_MSB:0];
          end else begin
            flag_d  = 1'b0;
          end
        end else if (!flag_q) begin
          state_d = ST_IDLE; // No ack without flag
        end else if (low_q >= CNT_W'(ACK_DELAY)) begin
          state_d = ST_ACK;
          low_d   = '0;
        end
      end

      ST_ACK: begin
        oe_d  = 1'b0; // Active-low pull-down
        low_d = low_q + CNT_W'(1);
        if (low_q >= CNT_W'(ACK_PULSE - 2)) begin
          state_d = ST_IDLE; // Bounded pulse
          oe_d    = 1'b1;
        end
      end

      default: state_d = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      line_q  <= 1'b1;
      low_q   <= '0;
      high_q  <= '0;
      nbits_q <= '0;
      shift_q <= '0;
      fpwm_q  <= 1'b0;
      valid_q <= 1'b0;
      sel_q   <= '0;
      val_q   <= '0;
      flag_q  <= 1'b0;
      bad_q   <= 1'b0;
      oe_q    <= 1'b1;
    end else begin
      state_q <= state_d;
      line_q  <= line_d;
      low_q   <= low_d;
      high_q  <= high_d;
      nbits_q <= nbits_d;
      shift_q <= shift_d;
      fpwm_q  <= fpwm_d;
      valid_q <= valid_d;
      sel_q   <= sel_d;
      val_q   <= val_d;
      flag_q  <= flag_d;
      bad_q   <= bad_d;
      oe_q    <= oe_d;
    end
  end

  // Pin and port outputs
  assign link.dev_oe  = oe_q;
  // Forced mode also follows line level at once
  assign o_forced_pwm = fpwm_q | link.line;
  assign o_cmd_valid  = valid_q;
  assign o_reg_select = sel_q;
  assign o_value      = val_q;
  assign o_ack_flag   = flag_q;
endmodule // one_pin_device

// ==== src/one_pin_host.sv ====
// Host end: sends two-byte commands and samples acknowledge
`timescale 1ns/10ps
module one_pin_host
  import one_pin_pkg::*;
#(
  parameter int SHORT = one_pin_pkg::HOST_BIT_SHORT,
  parameter int START = one_pin_pkg::HOST_START_CYCLES,
  parameter int EOSC  = one_pin_pkg::EOS_CYCLES,
  parameter int AWAIT = one_pin_pkg::HOST_ACK_WAIT
) (
  input  wire logic      i_clock,
  input  wire logic      i_resetn,
  one_pin_if.host        link,
  input  wire logic      i_send,
  input  wire logic      i_ack_req,
  input  wire logic [1:0] i_reg_select,
  input  wire logic [4:0] i_value,
  input  wire logic      i_power_save,
  output logic           o_busy,
  output logic           o_done,
  output logic           o_acked
);
  import one_pin_pkg::*;

  typedef enum {H_IDLE, H_START, H_LOW, H_HIGH, H_EOS, H_ACKW}
    hstate_e;

  hstate_e          st_q, st_d;
  logic [15:0]      word_q, word_d;
  logic [4:0]       idx_q, idx_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             oe_q, oe_d;
  logic             done_q, done_d;
  logic             ack_q, ack_d;
  logic             cur;

  assign cur = word_q[15];

  always_comb begin
    st_d   = st_q;
    word_d = word_q;
    idx_d  = idx_q;
    cnt_d  = cnt_q + CNT_W'(1);
    oe_d   = oe_q;
    done_d = 1'b0;
    ack_d  = ack_q;
    case (st_q)
      H_IDLE: begin
        oe_d = ~i_power_save; // Power-save after command
        if (i_send) begin
          // Address then data, flag only if requested
          word_d = {DEV_ADDR, i_ack_req, i_reg_select, i_value};
          idx_d  = '0;
          cnt_d  = '0;
          st_d   = H_START;
          oe_d   = 1'b1;
        end
      end
      H_START: begin
        if (cnt_q >= CNT_W'(START)) begin
          st_d = H_LOW;
          cnt_d = '0;
          oe_d = 1'b0;
        end
      end
      H_LOW: begin
        if (cnt_q >= CNT_W'(cur ? SHORT : 3 * SHORT)) begin
          st_d = H_HIGH;
          cnt_d = '0;
          oe_d = 1'b1;
        end
      end
      H_HIGH: begin
        if (cnt_q >= CNT_W'(cur ? 3 * SHORT : SHORT)) begin
          word_d = {word_q[14:0], 1'b0};
          idx_d  = idx_q + 5'd1;
          cnt_d  = '0;
          oe_d   = 1'b0;
          st_d   = (idx_q == 5'(CMD_BITS - 1)) ? H_ACKW : H_LOW;
        end
      end
      H_ACKW: begin
        if (cnt_q == CNT_W'(AWAIT)) begin
          oe_d = 1'b1;
        end else if (cnt_q == CNT_W'(AWAIT + 2)) begin
          ack_d = ~link.line;
          st_d  = H_EOS;
          cnt_d = '0;
        end
      end
      H_EOS: begin
        oe_d = 1'b1; // Released, pulled high
        if (cnt_q >= CNT_W'(EOSC) && link.line) begin
          st_d   = H_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_q   <= H_IDLE;
      word_q <= '0;
      idx_q  <= '0;
      cnt_q  <= '0;
      oe_q   <= 1'b1;
      done_q <= 1'b0;
      ack_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      word_q <= word_d;
      idx_q  <= idx_d;
      cnt_q  <= cnt_d;
      oe_q   <= oe_d;
      done_q <= done_d;
      ack_q  <= ack_d;
    end
  end

  assign link.host_oe = oe_q;
  assign o_busy       = (st_q != H_IDLE);
  assign o_done       = done_q;
  assign o_acked      = ack_q;
endmodule // one_pin_host

// ==== src/one_pin_if.sv ====
// Shared open-drain line between host and device
`timescale 1ns/10ps
interface one_pin_if;
  logic host_oe;
  logic dev_oe;
  logic line;
  // Pulled high unless either side enables its pull-down (oe low)
  assign line = host_oe & dev_oe;
  modport device (input line, output dev_oe);
  modport host   (input line, output host_oe);
endinterface

// ==== src/one_pin_pkg.sv ====
// Shared constants for the one-pin mode and command link
package one_pin_pkg;
  localparam logic [7:0] DEV_ADDR          = 8'h4E;
  localparam int         ACK_FLAG_POS      = 7;
  localparam int         SEL_HI_POS        = 6;
  localparam int         SEL_LO_POS        = 5;
  localparam int         VALUE_MSB         = 4;
  localparam int         CMD_BITS          = 16;
  localparam int         CLK_HZ            = 20_000_000;
  localparam int         ACK_PULSE_MAX_US  = 520;
  localparam int         ACK_PULSE_CYCLES  =
    (ACK_PULSE_MAX_US * (CLK_HZ / 1_000_000));
  localparam int         TIMEOUT_CYCLES    = 4000;
  localparam int         ACK_DELAY_CYCLES  = 200;
  localparam int         EOS_CYCLES        = 800;
  localparam int         TICK_DIV          = 1;
  localparam int         HOST_BIT_SHORT    = 20;
  localparam int         HOST_START_CYCLES = 100;
  localparam int         HOST_ACK_WAIT     = 300;
  localparam int         CNT_W             = 16;
endpackage

// ==== tb/one_pin_checker.sv ====
// Timing checks on the shared one-pin line
`timescale 1ns/10ps
module one_pin_checker #(
  parameter int TIMEOUT   = 400,
  parameter int ACK_DELAY = 20,
  parameter int ACK_PULSE = 50
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic line,
  input wire logic dev_oe,
  input wire logic o_forced_pwm,
  input wire logic o_cmd_valid,
  input wire logic o_ack_flag
);
  int low_q;
  int ack_q;
  always_ff @(posedge i_clock) begin
    low_q <= (!i_resetn || line) ? 0 : low_q + 1;
    ack_q <= (!i_resetn || dev_oe) ? 0 : ack_q + 1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence ack_start;
    $fell(dev_oe);
  endsequence
  sequence rx_fall;
    $fell(line) && o_forced_pwm;
  endsequence
  a_line_high_pwm: assert property (line |-> o_forced_pwm)
    else $error("forced mode low while line high");
  a_rx_keeps_pwm: assert property (rx_fall |-> o_forced_pwm [*8])
    else $error("forced mode dropped in a bit");
  a_timeout_save: assert property (low_q == TIMEOUT + 4 |-> !o_forced_pwm)
    else $error("no power save after long low");
  a_no_early_save: assert property
    (!line && low_q < TIMEOUT - 2 |-> o_forced_pwm)
    else $error("power save before timeout");
  a_valid_one_cycle: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("valid longer than one cycle");
  a_valid_line_low: assert property
    (o_cmd_valid |-> !line && !$past(line))
    else $error("valid outside final low");
  a_ack_needs_flag: assert property (ack_start |-> o_ack_flag)
    else $error("pull-down without ack flag");
  a_ack_after_delay: assert property
    (ack_start |-> $past(o_cmd_valid, ACK_DELAY + 1))
    else $error("pull-down not at validation delay");
  a_ack_pulse_len: assert property
    ($rose(dev_oe) |-> ack_q == ACK_PULSE - 2)
    else $error("pull-down length wrong");
endmodule // one_pin_checker

// ==== tb/one_pin_mode_and_command_decoder_test.sv ====
// Bench for host and device ends of the one-pin link
`timescale 1ns/10ps
module one_pin_mode_and_command_decoder_test;
  import one_pin_pkg::*;
  localparam int TO = 400;
  localparam int AD = 20;
  localparam int AP = 50;
  localparam int HE = 100;
  localparam int AW = 40;
  localparam int EO = 80;
  logic i_clock = 0, i_resetn = 0, i_send = 0, i_ack = 0, i_save = 0;
  logic [1:0] i_sel = '0, sel, sel2;
  logic [4:0] i_val = '0, val, val2;
  logic o_busy, o_done, o_acked, pwm, valid, flag, pwm2, valid2, flag2;
  int n_fail = 0, check_count = 0, cycles = 0;
  int n_valid = 0, n_valid2 = 0, n_ack = 0;
  one_pin_if link ();
  one_pin_if link2 ();
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    n_valid <= n_valid + (valid === 1'b1);
    n_valid2 <= n_valid2 + (valid2 === 1'b1);
    n_ack <= n_ack + (link.dev_oe === 1'b0);
    if (cycles == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  one_pin_host #(.SHORT(HOST_BIT_SHORT), .START(HOST_START_CYCLES),
    .EOSC(HE), .AWAIT(AW))
    one_pin_host_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link.host), .i_send(i_send), .i_ack_req(i_ack),
    .i_reg_select(i_sel), .i_value(i_val), .i_power_save(i_save),
    .o_busy(o_busy), .o_done(o_done), .o_acked(o_acked));
  one_pin_device #(.TIMEOUT(TO), .ACK_DELAY(AD), .ACK_PULSE(AP), .EOS(EO))
    one_pin_device_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link.device), .o_forced_pwm(pwm), .o_cmd_valid(valid),
    .o_reg_select(sel), .o_value(val), .o_ack_flag(flag));
  one_pin_device #(.TIMEOUT(TO), .ACK_DELAY(AD), .ACK_PULSE(AP), .EOS(EO))
    one_pin_device_inst_b (.i_clock(i_clock), .i_resetn(i_resetn),
    .link(link2.device), .o_forced_pwm(pwm2), .o_cmd_valid(valid2),
    .o_reg_select(sel2), .o_value(val2), .o_ack_flag(flag2));
  one_pin_checker #(.TIMEOUT(TO), .ACK_DELAY(AD), .ACK_PULSE(AP))
    one_pin_checker_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .line(link.line), .dev_oe(link.dev_oe), .o_forced_pwm(pwm),
    .o_cmd_valid(valid), .o_ack_flag(flag));
  task automatic check(input string name, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic host_cmd(input logic a, input logic [1:0] s,
                          input logic [4:0] v);
    int t;
    i_send <= 1;
    i_ack <= a;
    i_sel <= s;
    i_val <= v;
    @(posedge i_clock);
    i_send <= 0;
    for (t = 0; t < 5000 && o_done !== 1'b1; t++)
      @(posedge i_clock);
    check("done", o_done, 1);
    @(posedge i_clock);
  endtask
  task automatic cmd_codes();
    int nv;
    int na;
    for (int k = 0; k < 4; k++) begin
      nv = n_valid;
      na = n_ack;
      host_cmd(k[0], k[1:0], 5'h15 ^ k[4:0]);
      check("acked", o_acked, k[0]);
      check("ack low", 16'(n_ack - na), k[0] ? AP - 2 : 0);
      check("valid", 16'(n_valid - nv), 1);
      check("select", sel, k[1:0]);
      check("value", val, 5'h15 ^ k[4:0]);
      check("flag", flag, k[0]);
    end
  endtask
  task automatic power_save_mode();
    i_save <= 1;
    repeat (TO + 20) @(posedge i_clock);
    check("save mode", pwm, 0);
    i_save <= 0;
    repeat (3) @(posedge i_clock);
    check("forced mode", pwm, 1);
    repeat (100) @(posedge i_clock);
  endtask
  task automatic bang(input logic [15:0] w, input int bad, input int pre);
    if (pre > 0) begin
      link2.host_oe <= 0;
      repeat (pre) @(posedge i_clock);
      link2.host_oe <= 1;
      repeat (60) @(posedge i_clock);
    end else begin
      repeat (100) @(posedge i_clock);
    end
    for (int i = 15; i >= 0; i--) begin
      link2.host_oe <= 0;
      repeat ((i == bad) ? 40 : (w[i] ? 20 : 60)) @(posedge i_clock);
      link2.host_oe <= 1;
      repeat ((i == bad) ? 40 : (w[i] ? 60 : 20)) @(posedge i_clock);
    end
    link2.host_oe <= 0;
    repeat (40) @(posedge i_clock);
    link2.host_oe <= 1;
    repeat (100) @(posedge i_clock);
  endtask
  task automatic bad_frames();
    int nv;
    nv = n_valid2;
    bang(16'h4F9F, -1, 0);
    check("wrong address", 16'(n_valid2 - nv), 0);
    bang({DEV_ADDR, 8'h9F}, 3, 0);
    check("bad ratio", 16'(n_valid2 - nv), 0);
    bang({DEV_ADDR, 8'h9F}, -1, 30);
    check("early fall", 16'(n_valid2 - nv), 0);
    bang({DEV_ADDR, 8'h9F}, -1, 0);
    check("good frame", 16'(n_valid2 - nv), 1);
    check("select b", sel2, 2'h0);
    check("value b", val2, 5'h1F);
  endtask
  initial begin
    link2.host_oe = 1;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1;
    @(posedge i_clock);
    check("pwm at start", pwm, 1);
    cmd_codes();
    power_save_mode();
    bad_frames();
    complete_run();
  end
endmodule // one_pin_mode_and_command_decoder_test
